// ---- logic/tmr_regbank.sv ----
// Register bank of a three channel temperature monitor
`default_nettype none
`include "tmr_regs.svh"
module tmr_regbank #(
  parameter logic [7:0] MAKER_CODE = 8'h3C, // Arbitrary value
  parameter logic [7:0] REVISION_CODE = 8'h21 // Arbitrary value
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // Host access from the serial protocol engine
  input wire logic cmd_valid_i,
  input wire logic [7:0] cmd_byte_i,
  input wire logic wr_valid_i,
  input wire logic [7:0] wr_data_i,
  input wire logic rd_req_i,
  output logic [7:0] rd_data_o,
  output logic rd_valid_o,
  // Conversion engine results
  input wire logic conv_valid_i,
  input wire logic [7:0] local_hi_i,
  input wire logic [2:0] local_frac_i,
  input wire logic [7:0] r1_hi_signed_i,
  input wire logic [7:0] r1_hi_unsigned_i,
  input wire logic [4:0] r1_frac_i,
  input wire logic [7:0] r2_hi_signed_i,
  input wire logic [7:0] r2_hi_unsigned_i,
  input wire logic [4:0] r2_frac_i,
  input wire logic [3:0] diode_fault_i,
  input wire logic busy_i,
  input wire logic not_ready_i,
  // Controls toward the conversion engine
  output logic standby_select_o,
  output logic [1:0] conv_rate_o,
  output logic [4:0] chan_enable_o,
  output logic [3:0] filter_o,
  output logic [7:0] r1_offset_o,
  output logic [7:0] r2_offset_o,
  output logic oneshot_o,
  // Alert pins, active low
  output logic [2:0] alert_n_o
);
  tmr_pkg::tmr_state_t st_q;
  tmr_pkg::tmr_state_t st_d;
  logic [9:0] cmp_temp [5];
  logic [7:0] cmp_lim [5];
  logic [4:0] cmp_flag;
  logic [4:0] cmp_en;

  // Fraction bits 1..0 only show while the channel filter is on
  function automatic logic [7:0] frac_byte(input logic [4:0] frac, input logic [1:0] fsel);
    frac_byte = {frac[4:2], (fsel != 2'b00) ? frac[1:0] : 2'b00, 3'b000};
  endfunction

  function automatic logic alert_of(input logic [2:0] stat, input logic [7:0] mask);
    alert_of = ~|(stat & ~mask[2:0]);
  endfunction

  function automatic logic [7:0] wmask(input logic [7:0] d, input logic [7:0] m);
    wmask = d & m;
  endfunction

  // Flags: 0 local, 1 r1 first, 2 r2 first, 3 r1 second, 4 r2 second
  // Raw inputs, not st_d, so the compare never loops back into the state
  assign cmp_temp[0] = {local_hi_i[7], local_hi_i[7], local_hi_i};
  assign cmp_temp[1] = {2'b00, r1_hi_unsigned_i};
  assign cmp_temp[2] = {2'b00, r2_hi_unsigned_i};
  assign cmp_temp[3] = {2'b00, r1_hi_unsigned_i};
  assign cmp_temp[4] = {2'b00, r2_hi_unsigned_i};
  assign cmp_lim[0] = st_q.lim_l;
  assign cmp_lim[1] = st_q.lim_r1a;
  assign cmp_lim[2] = st_q.lim_r2a;
  assign cmp_lim[3] = st_q.lim_r1b;
  assign cmp_lim[4] = st_q.lim_r2b;
  assign cmp_en = {st_q.chen[2:1], st_q.chen[2:1], st_q.chen[0]};

  for (genvar gi = 0; gi < 5; gi++) begin : g_cmp
    tmr_limit_cmp u_cmp (
      .temp_i(cmp_temp[gi]),
      .limit_i(cmp_lim[gi]),
      .hyst_i(st_q.hyst),
      .flag_i(st_q.flags[gi]),
      .flag_o(cmp_flag[gi])
    );
  end

  always_comb begin
    logic [2:0] st2;
    logic [2:0] st3;
    st2 = '0;
    st3 = '0;
    st_d = st_q;
    st_d.oneshot = 1'b0;
    st_d.rd_valid = 1'b0;
    if (cmd_valid_i) begin
      st_d.ptr = cmd_byte_i;
    end
    if (wr_valid_i) begin
      // Read only locations fall to the default and are dropped
      case (st_q.ptr)
        `TMR_OFS_CONFIGURATION: st_d.config_r = wmask(wr_data_i, `TMR_MSK_CONFIGURATION);
        `TMR_OFS_CONV_RATE: st_d.rate = wmask(wr_data_i, `TMR_MSK_CONV_RATE);
        `TMR_OFS_CHAN_ENABLE: st_d.chen = wmask(wr_data_i, `TMR_MSK_CHAN_ENABLE);
        `TMR_OFS_FILTER: st_d.filt = wmask(wr_data_i, `TMR_MSK_FILTER);
        `TMR_OFS_ALERT1_MASK: st_d.mask1 = wmask(wr_data_i, `TMR_MSK_ALERT_MASK);
        `TMR_OFS_ALERT2_MASK: st_d.mask2 = wmask(wr_data_i, `TMR_MSK_ALERT_MASK);
        `TMR_OFS_ALERT3_MASK: st_d.mask3 = wmask(wr_data_i, `TMR_MSK_ALERT_MASK);
        `TMR_OFS_ONE_SHOT: st_d.oneshot = 1'b1;
        `TMR_OFS_R1_OFFSET: st_d.off1 = wr_data_i;
        `TMR_OFS_R2_OFFSET: st_d.off2 = wr_data_i;
        `TMR_OFS_LOCAL_LIMIT: st_d.lim_l = wmask(wr_data_i, `TMR_MSK_LOCAL_LIMIT);
        `TMR_OFS_R1_FIRST_LIM: st_d.lim_r1a = wr_data_i;
        `TMR_OFS_R2_FIRST_LIM: st_d.lim_r2a = wr_data_i;
        `TMR_OFS_R1_SECOND_LIM: st_d.lim_r1b = wr_data_i;
        `TMR_OFS_R2_SECOND_LIM: st_d.lim_r2b = wr_data_i;
        `TMR_OFS_HYSTERESIS: st_d.hyst = wmask(wr_data_i, `TMR_MSK_HYSTERESIS);
        default: st_d.oneshot = 1'b0;
      endcase
    end
    // New results land in the live copies; a frozen low byte is left alone
    if (conv_valid_i) begin
      st_d.hi_l = local_hi_i;
      st_d.hi_r1 = r1_hi_signed_i;
      st_d.hi_r2 = r2_hi_signed_i;
      st_d.hu_r1 = r1_hi_unsigned_i;
      st_d.hu_r2 = r2_hi_unsigned_i;
      st_d.fr_l = local_frac_i;
      st_d.fr_r1 = r1_frac_i;
      st_d.fr_r2 = r2_frac_i;
      st_d.fault = diode_fault_i;
      // Disabled channels drop their flags rather than hold stale ones
      st_d.flags = cmp_flag & cmp_en;
    end
    if (rd_req_i) begin
      st_d.rd_valid = 1'b1;
      st3 = {st_q.flags[4], st_q.flags[3], st_q.flags[0]};
      st2 = {st_q.flags[2], st_q.flags[1], st_q.flags[0]};
      case (st_q.ptr)
        `TMR_OFS_COMMON_STATUS: begin
          st_d.rd_data = {busy_i, not_ready_i, 2'b00, |st3, |st3, |st2, |st_q.fault};
        end
        `TMR_OFS_CONFIGURATION: st_d.rd_data = st_q.config_r;
        `TMR_OFS_CONV_RATE: st_d.rd_data = st_q.rate;
        `TMR_OFS_CHAN_ENABLE: st_d.rd_data = st_q.chen;
        `TMR_OFS_FILTER: st_d.rd_data = st_q.filt;
        `TMR_OFS_DIODE_FAULT: st_d.rd_data = {4'h0, st_q.fault};
        `TMR_OFS_ALERT1_STATUS: st_d.rd_data = {5'h00, st2};
        `TMR_OFS_ALERT2_STATUS: st_d.rd_data = {5'h00, st3};
        `TMR_OFS_ALERT3_STATUS: st_d.rd_data = {5'h00, st3};
        `TMR_OFS_ALERT1_MASK: st_d.rd_data = st_q.mask1;
        `TMR_OFS_ALERT2_MASK: st_d.rd_data = st_q.mask2;
        `TMR_OFS_ALERT3_MASK: st_d.rd_data = st_q.mask3;
        `TMR_OFS_LOCAL_HI, `TMR_PTR_RESET: begin
          st_d.rd_data = st_q.hi_l;
          st_d.fz_l = st_d.fr_l;
          st_d.lock[0] = 1'b1;
        end
        `TMR_OFS_R1_HI_S, `TMR_OFS_R1_HI_U: begin
          st_d.rd_data = (st_q.ptr == `TMR_OFS_R1_HI_S) ? st_q.hi_r1 : st_q.hu_r1;
          st_d.fz_r1 = st_d.fr_r1;
          st_d.lock[1] = 1'b1;
        end
        `TMR_OFS_R2_HI_S, `TMR_OFS_R2_HI_U: begin
          st_d.rd_data = (st_q.ptr == `TMR_OFS_R2_HI_S) ? st_q.hi_r2 : st_q.hu_r2;
          st_d.fz_r2 = st_d.fr_r2;
          st_d.lock[2] = 1'b1;
        end
        `TMR_OFS_LOCAL_LO: begin
          st_d.rd_data = {st_q.lock[0] ? st_q.fz_l : st_q.fr_l, 5'h00};
          st_d.lock[0] = 1'b0;
        end
        `TMR_OFS_R1_LO_S, `TMR_OFS_R1_LO_U: begin
          st_d.rd_data = frac_byte(st_q.lock[1] ? st_q.fz_r1 : st_q.fr_r1,
                                   st_q.filt[1:0]);
          st_d.lock[1] = 1'b0;
        end
        `TMR_OFS_R2_LO_S, `TMR_OFS_R2_LO_U: begin
          st_d.rd_data = frac_byte(st_q.lock[2] ? st_q.fz_r2 : st_q.fr_r2,
                                   st_q.filt[3:2]);
          st_d.lock[2] = 1'b0;
        end
        `TMR_OFS_R1_OFFSET: st_d.rd_data = st_q.off1;
        `TMR_OFS_R2_OFFSET: st_d.rd_data = st_q.off2;
        `TMR_OFS_LOCAL_LIMIT: st_d.rd_data = st_q.lim_l;
        `TMR_OFS_R1_FIRST_LIM: st_d.rd_data = st_q.lim_r1a;
        `TMR_OFS_R2_FIRST_LIM: st_d.rd_data = st_q.lim_r2a;
        `TMR_OFS_R1_SECOND_LIM: st_d.rd_data = st_q.lim_r1b;
        `TMR_OFS_R2_SECOND_LIM: st_d.rd_data = st_q.lim_r2b;
        `TMR_OFS_HYSTERESIS: st_d.rd_data = st_q.hyst;
        `TMR_OFS_MAKER_CODE: st_d.rd_data = MAKER_CODE;
        `TMR_OFS_REVISION: st_d.rd_data = REVISION_CODE;
        // One-shot, gaps and unmapped locations all read zero
        default: st_d.rd_data = 8'h00;
      endcase
    end
    // Alerts from next flags so pins and status agree in the same cycle
    st_d.alert_n[0] = alert_of({st_d.flags[2], st_d.flags[1], st_d.flags[0]}, st_d.mask1);
    st_d.alert_n[1] = alert_of({st_d.flags[4], st_d.flags[3], st_d.flags[0]}, st_d.mask2);
    st_d.alert_n[2] = alert_of({st_d.flags[4], st_d.flags[3], st_d.flags[0]}, st_d.mask3);
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      st_q <= '0;
      st_q.ptr <= `TMR_PTR_RESET;
      st_q.config_r <= `TMR_RST_CONFIGURATION;
      st_q.rate <= `TMR_RST_CONV_RATE;
      st_q.chen <= `TMR_RST_CHAN_ENABLE;
      st_q.filt <= `TMR_RST_FILTER;
      st_q.mask1 <= `TMR_RST_ALERT1_MASK;
      st_q.mask2 <= `TMR_RST_ALERT2_MASK;
      st_q.mask3 <= `TMR_RST_ALERT3_MASK;
      st_q.off1 <= `TMR_RST_OFFSET;
      st_q.off2 <= `TMR_RST_OFFSET;
      st_q.lim_l <= `TMR_RST_LOCAL_LIMIT;
      st_q.lim_r1a <= `TMR_RST_FIRST_LIM;
      st_q.lim_r2a <= `TMR_RST_FIRST_LIM;
      st_q.lim_r1b <= `TMR_RST_SECOND_LIM;
      st_q.lim_r2b <= `TMR_RST_SECOND_LIM;
      st_q.hyst <= `TMR_RST_HYSTERESIS;
      st_q.alert_n <= 3'h7;
    end else begin
      st_q <= st_d;
    end
  end

  assign rd_data_o = st_q.rd_data;
  assign rd_valid_o = st_q.rd_valid;
  assign standby_select_o = st_q.config_r[`TMR_BIT_STANDBY];
  assign conv_rate_o = st_q.rate[1:0];
  assign chan_enable_o = st_q.chen[4:0];
  assign filter_o = st_q.filt[3:0];
  assign r1_offset_o = st_q.off1;
  assign r2_offset_o = st_q.off2;
  assign oneshot_o = st_q.oneshot;
  assign alert_n_o = st_q.alert_n;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  chk_ptr_load: assert property (
    cmd_valid_i |=> st_q.ptr == $past(cmd_byte_i))
    else $error("pointer did not take the command byte");

  chk_ptr_reset: assert property (
    $fell(reset_i) |-> st_q.ptr == 8'h00 && st_q.lim_l == 8'h55 && st_q.lim_r1a == 8'h6E)
    else $error("pointer or limits wrong after reset");

  chk_local_lo_zero: assert property (
    rd_req_i && st_q.ptr == `TMR_OFS_LOCAL_LO |=> rd_valid_o && rd_data_o[4:0] == 5'h00)
    else $error("local low byte reserved bits not zero");

  chk_lock_freeze: assert property (
    rd_req_i && st_q.ptr == `TMR_OFS_R1_HI_S && !conv_valid_i
      |=> st_q.lock[1] && st_q.fz_r1 == $past(st_q.fr_r1))
    else $error("high byte read did not freeze low byte");

  chk_lock_release: assert property (
    rd_req_i && st_q.ptr == `TMR_OFS_LOCAL_LO |=> !st_q.lock[0])
    else $error("low byte read did not release freeze");

  chk_frozen_kept: assert property (
    st_q.lock[2] && !(rd_req_i && (st_q.ptr == `TMR_OFS_R2_HI_S
      || st_q.ptr == `TMR_OFS_R2_HI_U)) |=> $stable(st_q.fz_r2))
    else $error("frozen low byte changed without a high byte read");

  chk_filter_off: assert property (
    rd_req_i && st_q.ptr == `TMR_OFS_R1_LO_S && st_q.filt[1:0] == 2'b00
      |=> rd_data_o[4:0] == 5'h00)
    else $error("filter off low byte shows fine bits");

  chk_oneshot_pulse: assert property (
    wr_valid_i && st_q.ptr == `TMR_OFS_ONE_SHOT |=> oneshot_o
      ##1 (!oneshot_o || $past(wr_valid_i && st_q.ptr == `TMR_OFS_ONE_SHOT)))
    else $error("one-shot write did not give one pulse");

  chk_ro_write: assert property (
    wr_valid_i && st_q.ptr == `TMR_OFS_LOCAL_HI && !cmd_valid_i
      |=> $stable(st_q.lim_l) && $stable(st_q.chen) && $stable(st_q.ptr))
    else $error("write to read only location changed state");

  chk_alert_hold: assert property (
    st_q.flags[0] && !st_q.mask1[0] |-> !alert_n_o[0])
    else $error("unmasked local flag without alert");

  chk_limit_rsvd: assert property (
    st_q.lim_l[7] == 1'b0 && st_q.hyst[7:5] == 3'h0)
    else $error("reserved limit bits set");

  chk_unmapped_zero: assert property (
    rd_req_i && st_q.ptr == 8'h01 |=> rd_valid_o && rd_data_o == 8'h00)
    else $error("unmapped location did not read zero");

  chk_oneshot_read: assert property (
    rd_req_i && st_q.ptr == `TMR_OFS_ONE_SHOT |=> rd_data_o == 8'h00)
    else $error("one-shot location did not read zero");

  chk_alias_local: assert property (
    rd_req_i && st_q.ptr == `TMR_PTR_RESET |=> rd_data_o == $past(st_q.hi_l) && st_q.lock[0])
    else $error("location 00 did not act as local high byte");

  chk_hi_unsigned: assert property (
    rd_req_i && st_q.ptr == `TMR_OFS_R1_HI_U |=> rd_data_o == $past(st_q.hu_r1))
    else $error("unsigned high byte read wrong");

  // Flags move only on a conversion, so a stale alert cannot appear between rounds
  chk_flags_stable: assert property (
    !conv_valid_i |=> $stable(st_q.flags))
    else $error("flags moved without a conversion");

  chk_alert_masked: assert property (
    &st_q.mask3[2:0] |-> alert_n_o[2])
    else $error("fully masked third alert is active");

  chk_local_over: assert property (
    conv_valid_i && st_q.chen[0] && !local_hi_i[7] && local_hi_i > st_q.lim_l
      |=> st_q.flags[0])
    else $error("local reading above limit did not set flag");

  chk_status_ro: assert property (
    wr_valid_i && st_q.ptr == `TMR_OFS_ALERT1_STATUS |=> $stable(st_q.mask1) && $stable(st_q.hyst))
    else $error("write to status location changed state");

  chk_hyst_write: assert property (
    wr_valid_i && st_q.ptr == `TMR_OFS_HYSTERESIS
      |=> st_q.hyst == ($past(wr_data_i) & `TMR_MSK_HYSTERESIS))
    else $error("hysteresis reserved bits took a write");
endmodule // tmr_regbank
`default_nettype wire

// ---- logic/tmr_regs.svh ----
// Register offsets, field masks and reset values of the thermal monitor register bank
`ifndef TMR_REGS_SVH
`define TMR_REGS_SVH

`define TMR_OFS_COMMON_STATUS 8'h02
`define TMR_OFS_CONFIGURATION 8'h03
`define TMR_OFS_CONV_RATE 8'h04
`define TMR_OFS_CHAN_ENABLE 8'h05
`define TMR_OFS_FILTER 8'h06
`define TMR_OFS_DIODE_FAULT 8'h07
`define TMR_OFS_ALERT1_STATUS 8'h08
`define TMR_OFS_ALERT2_STATUS 8'h09
`define TMR_OFS_ALERT3_STATUS 8'h0A
`define TMR_OFS_ALERT1_MASK 8'h0C
`define TMR_OFS_ALERT2_MASK 8'h0D
`define TMR_OFS_ALERT3_MASK 8'h0E
`define TMR_OFS_ONE_SHOT 8'h0F
`define TMR_OFS_LOCAL_HI 8'h10
`define TMR_OFS_R1_HI_S 8'h11
`define TMR_OFS_R2_HI_S 8'h12
`define TMR_OFS_R1_HI_U 8'h19
`define TMR_OFS_R2_HI_U 8'h1A
`define TMR_OFS_LOCAL_LO 8'h20
`define TMR_OFS_R1_LO_S 8'h21
`define TMR_OFS_R2_LO_S 8'h22
`define TMR_OFS_R1_LO_U 8'h29
`define TMR_OFS_R2_LO_U 8'h2A
`define TMR_OFS_R1_OFFSET 8'h31
`define TMR_OFS_R2_OFFSET 8'h32
`define TMR_OFS_LOCAL_LIMIT 8'h40
`define TMR_OFS_R1_FIRST_LIM 8'h41
`define TMR_OFS_R2_FIRST_LIM 8'h42
`define TMR_OFS_R1_SECOND_LIM 8'h49
`define TMR_OFS_R2_SECOND_LIM 8'h4A
`define TMR_OFS_HYSTERESIS 8'h5A
`define TMR_OFS_MAKER_CODE 8'hFE
`define TMR_OFS_REVISION 8'hFF

`define TMR_PTR_RESET 8'h00
`define TMR_RST_CONFIGURATION 8'h00
`define TMR_RST_CONV_RATE 8'h02
`define TMR_RST_CHAN_ENABLE 8'h1F
`define TMR_RST_FILTER 8'h0F
`define TMR_RST_ALERT1_MASK 8'h01
`define TMR_RST_ALERT2_MASK 8'h00
`define TMR_RST_ALERT3_MASK 8'h07
`define TMR_RST_OFFSET 8'h00
`define TMR_RST_LOCAL_LIMIT 8'h55
`define TMR_RST_FIRST_LIM 8'h6E
`define TMR_RST_SECOND_LIM 8'h55
`define TMR_RST_HYSTERESIS 8'h0A

`define TMR_MSK_CONFIGURATION 8'h40
`define TMR_MSK_CONV_RATE 8'h03
`define TMR_MSK_CHAN_ENABLE 8'h1F
`define TMR_MSK_FILTER 8'h0F
`define TMR_MSK_ALERT_MASK 8'h07
`define TMR_MSK_LOCAL_LIMIT 8'h7F
`define TMR_MSK_HYSTERESIS 8'h1F

`define TMR_BIT_STANDBY 6
`define TMR_BIT_BUSY 7
`define TMR_BIT_NOT_READY 6

`endif

// ---- logic/tmr_pkg.sv ----
// Types of the thermal monitor register bank
`default_nettype none
package tmr_pkg;

  typedef struct packed {
    logic [7:0] ptr;
    logic [7:0] config_r;
    logic [7:0] rate;
    logic [7:0] chen;
    logic [7:0] filt;
    logic [7:0] mask1;
    logic [7:0] mask2;
    logic [7:0] mask3;
    logic [7:0] off1;
    logic [7:0] off2;
    logic [7:0] lim_l;
    logic [7:0] lim_r1a;
    logic [7:0] lim_r2a;
    logic [7:0] lim_r1b;
    logic [7:0] lim_r2b;
    logic [7:0] hyst;
    logic [7:0] hi_l;
    logic [7:0] hi_r1;
    logic [7:0] hi_r2;
    logic [7:0] hu_r1;
    logic [7:0] hu_r2;
    logic [2:0] fr_l;
    logic [4:0] fr_r1;
    logic [4:0] fr_r2;
    logic [2:0] fz_l;
    logic [4:0] fz_r1;
    logic [4:0] fz_r2;
    logic [2:0] lock;
    logic [3:0] fault;
    logic [4:0] flags;
    logic [2:0] alert_n;
    logic oneshot;
    logic [7:0] rd_data;
    logic rd_valid;
  } tmr_state_t;

endpackage : tmr_pkg
`default_nettype wire

// ---- logic/tmr_limit_cmp.sv ----
// Limit comparator with shared hysteresis for one channel
`default_nettype none
module tmr_limit_cmp (
  // Sample and thresholds
  input wire logic [9:0] temp_i,
  input wire logic [7:0] limit_i,
  input wire logic [7:0] hyst_i,
  // Flag
  input wire logic flag_i,
  output logic flag_o
);
  logic signed [9:0] lim_s;
  logic signed [9:0] low_s;
  logic over;
  logic under;

  // Ten bits keep limit minus hysteresis from wrapping below zero
  assign lim_s = signed'({2'b00, limit_i});
  assign low_s = lim_s - signed'({2'b00, hyst_i});
  assign over = signed'(temp_i) > lim_s;
  assign under = signed'(temp_i) < low_s;
  assign flag_o = over | (flag_i & ~under);
endmodule // tmr_limit_cmp
`default_nettype wire

// ---- tb/tmr_host_model.sv ----
// Host side model that issues command, write and read transfers
`default_nettype none
module tmr_host_model (
  // Clock
  input wire logic clk_i,
  // Requests toward the register bank
  output logic cmd_valid_o,
  output logic [7:0] cmd_byte_o,
  output logic wr_valid_o,
  output logic [7:0] wr_data_o,
  output logic rd_req_o,
  // Answers from the register bank
  input wire logic [7:0] rd_data_i,
  input wire logic rd_valid_i
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    cmd_valid_o = 1'b0;
    cmd_byte_o = 8'hA5;
    wr_valid_o = 1'b0;
    wr_data_o = 8'h5A;
    rd_req_o = 1'b0;
  end

  // Command byte first, then data; idle lines show the inverse, never a stale copy
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_i);
    cmd_valid_o = 1'b1;
    cmd_byte_o = a;
    @(negedge clk_i);
    cmd_valid_o = 1'b0;
    cmd_byte_o = ~a;
    wr_valid_o = 1'b1;
    wr_data_o = d;
    @(negedge clk_i);
    wr_valid_o = 1'b0;
    wr_data_o = ~d;
  endtask

  // Optional pointer set, then one read; the caller orders high before low
  task automatic rd(input logic set, input logic [7:0] a, output logic [7:0] d,
                    output logic ok);
    int n;
    if (set) begin
      @(negedge clk_i);
      cmd_valid_o = 1'b1;
      cmd_byte_o = a;
    end
    @(negedge clk_i);
    cmd_valid_o = 1'b0;
    cmd_byte_o = ~a;
    rd_req_o = 1'b1;
    @(negedge clk_i);
    rd_req_o = 1'b0;
    ok = 1'b0;
    d = 8'h00;
    for (n = 0; n < 4 && !ok; n++) begin
      if (rd_valid_i === 1'b1) begin
        d = rd_data_i;
        ok = 1'b1;
      end else begin
        @(negedge clk_i);
      end
    end
  endtask
endmodule // tmr_host_model
`default_nettype wire

// ---- tb/tmr_regbank_tb.sv ----
// Self-checking testbench of the thermal monitor register bank
`default_nettype none
module tmr_regbank_tb;
  timeunit 1ns;
  timeprecision 1ns;
  // Arbitrary identity values
  localparam logic [7:0] MAKER = 8'h3C;
  localparam logic [7:0] REV = 8'h21;
  localparam logic [15:0] RST_TAB [16] = '{16'h0200, 16'h0300, 16'h0402, 16'h051F,
    16'h060F, 16'h0C01, 16'h0D00, 16'h0E07, 16'h3100, 16'h3200, 16'h4055, 16'h416E,
    16'h426E, 16'h4955, 16'h4A55, 16'h5A0A};
  localparam logic [15:0] MSK_TAB [15] = '{16'h0340, 16'h0403, 16'h051F, 16'h060F,
    16'h0C07, 16'h0D07, 16'h0E07, 16'h31FF, 16'h32FF, 16'h407F, 16'h41FF, 16'h42FF,
    16'h49FF, 16'h4AFF, 16'h5A1F};

  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic cmd_valid, wr_valid, rd_req, rd_valid, conv_v = 1'b0;
  logic [7:0] cmd_byte, wr_data, rd_data;
  logic [7:0] lh = 8'h00, r1s = 8'h00, r1u = 8'h00, r2s = 8'h00, r2u = 8'h00;
  logic [2:0] lf = 3'h0;
  logic [4:0] r1f = 5'h00, r2f = 5'h00;
  logic [3:0] dfault = 4'h0;
  logic busy = 1'b0, nrdy = 1'b0;
  logic standby_select_o, oneshot_o;
  logic [1:0] conv_rate_o;
  logic [4:0] chan_enable_o;
  logic [3:0] filter_o;
  logic [7:0] r1_offset_o, r2_offset_o;
  logic [2:0] alert_n_o;
  int n_fail = 0, comparisons = 0, n_shot = 0;

  always #50 clk_i = ~clk_i;
  always @(posedge clk_i) if (oneshot_o === 1'b1) n_shot++;

  tmr_host_model host (.clk_i(clk_i), .cmd_valid_o(cmd_valid), .cmd_byte_o(cmd_byte),
    .wr_valid_o(wr_valid), .wr_data_o(wr_data), .rd_req_o(rd_req), .rd_data_i(rd_data),
    .rd_valid_i(rd_valid));

  tmr_regbank #(.MAKER_CODE(MAKER), .REVISION_CODE(REV)) uut (.clk_i(clk_i),
    .reset_i(reset_i), .cmd_valid_i(cmd_valid), .cmd_byte_i(cmd_byte),
    .wr_valid_i(wr_valid), .wr_data_i(wr_data), .rd_req_i(rd_req), .rd_data_o(rd_data),
    .rd_valid_o(rd_valid), .conv_valid_i(conv_v), .local_hi_i(lh), .local_frac_i(lf),
    .r1_hi_signed_i(r1s), .r1_hi_unsigned_i(r1u), .r1_frac_i(r1f), .r2_hi_signed_i(r2s),
    .r2_hi_unsigned_i(r2u), .r2_frac_i(r2f), .diode_fault_i(dfault), .busy_i(busy),
    .not_ready_i(nrdy), .standby_select_o(standby_select_o), .conv_rate_o(conv_rate_o),
    .chan_enable_o(chan_enable_o), .filter_o(filter_o), .r1_offset_o(r1_offset_o),
    .r2_offset_o(r2_offset_o), .oneshot_o(oneshot_o), .alert_n_o(alert_n_o));

  task automatic results();
    if (n_fail == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Read with optional pointer set; a missing answer counts and ends the run
  task automatic rc_p(input logic set, input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    logic ok;
    host.rd(set, a, d, ok);
    if (!ok) begin
      n_fail++;
      $display("[FAIL] %0t no read answer at %h", $time, a);
      results();
    end
    chk(d, exp);
  endtask

  task automatic rc(input logic [7:0] a, input logic [7:0] exp);
    rc_p(1'b1, a, exp);
  endtask

  // Results and flags change together on the conversion pulse; one extra idle cycle follows
  task automatic cv();
    @(negedge clk_i);
    conv_v = 1'b1;
    @(negedge clk_i);
    conv_v = 1'b0;
    @(negedge clk_i);
  endtask

  task automatic do_reset();
    reset_i = 1'b1;
    repeat (12) @(negedge clk_i);
    reset_i = 1'b0;
    @(negedge clk_i);
  endtask

  initial begin
    do_reset();
    // Pointer after reset, read without a command byte
    lh = 8'h3C;
    cv();
    rc_p(1'b0, 8'h00, 8'h3C);
    chk({5'h00, alert_n_o}, 8'h07);
    chk({7'h00, standby_select_o}, 8'h00);
    chk({6'h00, conv_rate_o}, 8'h02);
    chk({3'h0, chan_enable_o}, 8'h1F);
    chk({4'h0, filter_o}, 8'h0F);
    for (int i = 0; i < 16; i++) rc(RST_TAB[i][15:8], RST_TAB[i][7:0]);
    rc(8'hFE, MAKER);
    rc(8'hFF, REV);
    // Writable fields, reserved bits read zero
    for (int i = 0; i < 15; i++) host.wr(MSK_TAB[i][15:8], 8'hFF);
    for (int i = 0; i < 15; i++) rc(MSK_TAB[i][15:8], MSK_TAB[i][7:0]);
    chk({7'h00, standby_select_o}, 8'h01);
    chk({6'h00, conv_rate_o}, 8'h03);
    chk({4'h0, filter_o}, 8'h0F);
    chk(r1_offset_o, 8'hFF);
    chk(r2_offset_o, 8'hFF);
    do_reset();
    // Read-only, one-shot and unmapped places
    host.wr(8'h10, 8'hA5);
    rc(8'h10, 8'h00);
    host.wr(8'h08, 8'hFF);
    rc(8'h08, 8'h00);
    host.wr(8'hFE, 8'h00);
    rc(8'hFE, MAKER);
    n_shot = 0;
    host.wr(8'h0F, 8'hFF);
    repeat (2) @(negedge clk_i);
    chk(8'(n_shot), 8'h01);
    rc(8'h0F, 8'h00);
    host.wr(8'h01, 8'h77);
    rc(8'h01, 8'h00);
    // Formats and the low byte freeze
    lh = 8'h9C; lf = 3'b101; r1s = 8'h85; r1u = 8'hE0; r1f = 5'b10111;
    r2s = 8'hF0; r2u = 8'h33; r2f = 5'b11111;
    cv();
    rc(8'h10, 8'h9C);
    rc(8'h20, 8'hA0);
    rc(8'h11, 8'h85);
    rc(8'h12, 8'hF0);
    rc(8'h19, 8'hE0);
    rc(8'h1A, 8'h33);
    r1f = 5'b01000;
    cv();
    rc(8'h21, 8'hB8);
    rc(8'h21, 8'h40);
    rc(8'h11, 8'h85);
    r1f = 5'b11111;
    cv();
    rc(8'h19, 8'hE0);
    r1f = 5'b00000;
    cv();
    rc(8'h29, 8'hF8);
    rc(8'h22, 8'hF8);
    host.wr(8'h06, 8'h00);
    r1f = 5'b11011;
    cv();
    rc(8'h22, 8'hE0);
    rc(8'h21, 8'hC0);
    rc(8'h2A, 8'hE0);
    do_reset();
    // Limit boundary, hysteresis and alert masking
    lh = 8'h55; lf = 3'b000; r1u = 8'h00; r2u = 8'h00; r1f = 5'h00; r2f = 5'h00;
    cv();
    rc(8'h08, 8'h00);
    lh = 8'h56;
    busy = 1'b1;
    cv();
    rc(8'h08, 8'h01);
    rc(8'h09, 8'h01);
    rc(8'h02, 8'h8E);
    chk({5'h00, alert_n_o}, 8'h05);
    lh = 8'h4B;
    cv();
    rc(8'h0A, 8'h01);
    lh = 8'h4A;
    cv();
    rc(8'h08, 8'h00);
    chk({5'h00, alert_n_o}, 8'h07);
    busy = 1'b0;
    r1u = 8'h6F;
    dfault = 4'b1010;
    cv();
    rc(8'h08, 8'h02);
    rc(8'h09, 8'h02);
    rc(8'h07, 8'h0A);
    chk({5'h00, alert_n_o}, 8'h04);
    nrdy = 1'b1;
    rc(8'h02, 8'h4F);
    r1u = 8'h00;
    lh = 8'h60;
    host.wr(8'h05, 8'h1E);
    cv();
    rc(8'h08, 8'h00);
    r2u = 8'h6F;
    cv();
    rc(8'h08, 8'h04);
    rc(8'h0A, 8'h04);
    chk({5'h00, alert_n_o}, 8'h04);
    results();
  end
endmodule // tmr_regbank_tb
`default_nettype wire
